// *** core/ubrt_map.svh ***
`ifndef UBRT_MAP_SVH
`define UBRT_MAP_SVH

// Core clock in kHz (100 MHz)
`define UBRT_CLK_KHZ 100000
// Bit rate of the serial line
`define UBRT_BAUD 9600
// Half-bit alignment delay in microseconds
`define UBRT_HALF_BIT_US 52
// Latch clear delay in microseconds
`define UBRT_CLEAR_US 924
// Oscillator tap divide ratio (core cycles per oscillator tick)
`define UBRT_OSC_DIV 4
// Data bits per frame and bits per frame
`define UBRT_DATA_BITS 8
`define UBRT_FRAME_BITS 10
// Extra settle cycles before the frame ends
`define UBRT_END_PAD 3

`endif

// *** core/ubrt_pkg.sv ***
package ubrt_pkg;

    // Receiver sequencing states, one-hot
    typedef enum logic [3:0] {
        UBRT_IDLE  = 4'b0001,
        UBRT_ALIGN = 4'b0010,
        UBRT_SHIFT = 4'b0100,
        UBRT_END   = 4'b1000
    } ubrt_state_e;

endpackage

// *** core/ubrt_receiver.sv ***
// Notes on behaviour
// - Falling edge on line pulses and sets latch
// - Latch clears about nine bits after set
// - Shifter enabled only while frame end low
// - Latch high lets line shift into shifter
// - Latch delayed half a bit before clocking
// - Delayed latch gates oscillator into counter
// - Counter idle until start seen and enabled
// - Counter output shifts one bit per period
// - Byte presented in parallel after frame
`include "ubrt_map.svh"

module ubrt_receiver
    import ubrt_pkg::*;
#(
    parameter int CLK_KHZ = `UBRT_CLK_KHZ,
    parameter int BAUD = `UBRT_BAUD,
    parameter int HALF_BIT_US = `UBRT_HALF_BIT_US,
    parameter int CLEAR_US = `UBRT_CLEAR_US,
    parameter int OSC_DIV = `UBRT_OSC_DIV
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic serial_in,
    output logic [7:0] data_out,
    output logic data_valid,
    input wire logic data_ready,
    output logic start_latch,
    output logic shifter_enable_n
);

    // Derived cycle counts; half-bit rounds up, clear delay rounds down
    localparam int HALF_CYC = (HALF_BIT_US * CLK_KHZ + 999) / 1000;
    localparam int CLEAR_CYC = (CLEAR_US * CLK_KHZ) / 1000;
    // Oscillator ticks per bit; quotient rounded to nearest
    localparam int BIT_TICKS = ((CLK_KHZ * 1000) / OSC_DIV + BAUD / 2) / BAUD;
    // Counter width; holds the longest span, the clear delay, up to about a million cycles
    localparam int CW = 20;

    // Complete register state of the receiver
    typedef struct packed {
        // Two-stage synchroniser for the asynchronous line
        logic sync1;
        logic sync2;
        // Line one cycle older than sync2, for the falling-edge compare
        logic line_d;
        // Frame latch, set by the start edge
        logic latch;
        // Cycles since the latch was set; clears it at the end of its span
        logic [CW-1:0] clear_cnt;
        // Half-bit alignment counter
        logic [CW-1:0] half_cnt;
        // Delayed latch: gates the oscillator tap into the bit counter
        logic half_done;
        // Free-running divider that makes the oscillator tap
        logic [3:0] osc_cnt;
        // Bit counter, advanced only by gated oscillator ticks
        logic [CW-1:0] bit_cnt;
        // Samples taken in this frame, start bit included
        logic [3:0] bits;
        // Shift register, filled from the top so the first bit ends at bit 0
        logic [7:0] shreg;
        // Frame-end level; high keeps the shifter disabled
        logic frame_end;
        // Settle cycles after the last data sample
        logic [1:0] pad;
        // Fill level of the two-entry output buffer
        logic [1:0] buf_cnt;
        // Head and tail entries of the buffer
        logic [7:0] buf0;
        logic [7:0] buf1;
        // Sequencing state
        ubrt_state_e state;
    } ubrt_state_s;

    ubrt_state_s cur;
    ubrt_state_s next_cur;

    // Terms shared by the next-state logic and the output buffer
    logic fall_pulse; // One-cycle pulse on a falling line edge
    logic osc_tap; // One core cycle in OSC_DIV
    logic gated_clk; // Oscillator tap passed only after the half-bit delay
    logic bit_tick; // One pulse per bit period
    logic frame_done; // Last settle cycle of a frame
    logic push; // Finished byte enters the buffer
    logic pop; // Head byte leaves the buffer

    // Edge, gating and buffer terms used by the next-state logic
    always_comb begin
        // Falling edge: the older copy still high, the newer one low
        fall_pulse = cur.line_d & ~cur.sync2;
        // Oscillator tap divides the core clock down
        osc_tap = (cur.osc_cnt == 4'(OSC_DIV - 1));
        // The delayed latch is the gate, so no tick comes before mid start bit
        gated_clk = cur.half_done & osc_tap;
        // Terminal count of the bit counter sets the bit rate
        bit_tick = gated_clk && (cur.bit_cnt == CW'(BIT_TICKS - 1));
        // Push on the last settle cycle if an entry is free; pop on ready
        frame_done = (cur.state == UBRT_END) && (cur.pad == 2'(`UBRT_END_PAD - 1));
        push = frame_done && (cur.buf_cnt != 2'd2);
        pop = (cur.buf_cnt != 2'd0) && data_ready;
    end

    // Next-state computation for every field
    always_comb begin
        next_cur = cur;
        // Every field holds unless a branch below moves it
        // Two flops before the line is looked at
        next_cur.sync1 = serial_in;
        next_cur.sync2 = cur.sync1;
        next_cur.line_d = cur.sync2;
        // Oscillator tap free-runs
        next_cur.osc_cnt = osc_tap ? 4'h0 : cur.osc_cnt + 4'h1;
        // Start latch set on falling edge, only when idle
        if (fall_pulse && !cur.latch && cur.state == UBRT_IDLE) begin
            next_cur.latch = 1'b1;
            next_cur.clear_cnt = '0;
            next_cur.half_cnt = '0;
            next_cur.state = UBRT_ALIGN;
        end
        // Latch clear timer runs while latch is high
        // Set and clear never meet: a set needs the latch low
        if (cur.latch) begin
            if (cur.clear_cnt == CW'(CLEAR_CYC - 1)) begin
                next_cur.latch = 1'b0;
            end else begin
                next_cur.clear_cnt = cur.clear_cnt + 1'b1;
            end
        end
        unique case (cur.state)
            UBRT_IDLE: begin
                // Gate closed and shifter disabled until a start edge
                next_cur.half_done = 1'b0;
                next_cur.frame_end = 1'b1;
            end
            UBRT_ALIGN: begin
                // Half-bit delay of the latch output
                if (cur.half_cnt == CW'(HALF_CYC - 1)) begin
                    next_cur.half_done = 1'b1;
                    // Preload so the first gated tick samples the start bit
                    next_cur.bit_cnt = CW'(BIT_TICKS - 1);
                    next_cur.bits = 4'h0;
                    next_cur.frame_end = 1'b0;
                    next_cur.state = UBRT_SHIFT;
                end else begin
                    // Still waiting out the half bit
                    next_cur.half_cnt = cur.half_cnt + 1'b1;
                end
            end
            UBRT_SHIFT: begin
                // Counter only advances on gated oscillator ticks
                if (gated_clk) begin
                    // Wraps at terminal count, so one tick per bit period
                    next_cur.bit_cnt = bit_tick ? '0 : cur.bit_cnt + 1'b1;
                end
                if (bit_tick) begin
                    // Start bit sample is discarded, data LSB first
                    if (cur.bits != 4'h0 && !cur.frame_end) begin
                        next_cur.shreg = {cur.sync2, cur.shreg[7:1]};
                    end
                    next_cur.bits = cur.bits + 4'h1;
                    // The ninth sample is the last data bit; go settle
                    if (cur.bits == 4'(`UBRT_DATA_BITS)) begin
                        next_cur.pad = '0;
                        next_cur.state = UBRT_END;
                    end
                end
            end
            UBRT_END: begin
                // Short settle so the last bit lands before shutting off
                if (frame_done) begin
                    next_cur.frame_end = 1'b1;
                    next_cur.half_done = 1'b0;
                    next_cur.state = UBRT_IDLE;
                    // Overflow drops the word only if both entries full;
                    // the older bytes win, so a stalled reader keeps its order
                    if (push) begin
                        // Head when empty or when the head leaves this cycle
                        if (cur.buf_cnt == 2'd0 || (cur.buf_cnt == 2'd1 && data_ready)) begin
                            next_cur.buf0 = cur.shreg;
                        end else begin
                            next_cur.buf1 = cur.shreg;
                        end
                    end
                end else begin
                    next_cur.pad = cur.pad + 2'd1;
                end
            end
            default: begin
                // Illegal one-hot code: fall back to idle
                next_cur.state = UBRT_IDLE;
            end
        endcase
        // Two-entry buffer: pop then push bookkeeping
        // A pop from a full buffer moves the tail up to the head
        if (pop && cur.buf_cnt == 2'd2) begin
            next_cur.buf0 = cur.buf1;
        end
        // Push and pop together leave the fill level as it was
        next_cur.buf_cnt = cur.buf_cnt + 2'(push) - 2'(pop);
    end

    // Single register stage, frozen while clock enable is low
    // Synchroniser resets to the idle line level, so no false edge follows reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cur <= '{sync1: 1'b1, sync2: 1'b1, line_d: 1'b1, frame_end: 1'b1,
                     state: UBRT_IDLE, default: '0};
        end else if (clk_en) begin
            cur <= next_cur;
        end
    end

    // Outputs from state
    // Byte from the head register; valid while the buffer holds anything
    assign data_out = cur.buf0;
    assign data_valid = (cur.buf_cnt != 2'd0);
    // Latch and frame-end levels leave straight from their flops
    assign start_latch = cur.latch;
    assign shifter_enable_n = cur.frame_end;

endmodule

// *** verif/ubrt_checker_sva.sv ***
module ubrt_checker #(
    parameter int CLK_KHZ = 1000,
    parameter int BAUD = 9600,
    parameter int HALF_BIT_US = 52,
    parameter int CLEAR_US = 924
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire logic serial_in,
    input wire logic [7:0] data_out,
    input wire logic data_valid,
    input wire logic data_ready,
    input wire logic start_latch,
    input wire logic shifter_enable_n
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = HALF_BIT_US * CLK_KHZ / 1000;
    localparam int BIT = CLK_KHZ * 1000 / BAUD;
    localparam int CLR = CLEAR_US * CLK_KHZ / 1000;
    localparam int ENDC = HALF + 8 * BIT + 3;
    // Cycles since the latch last rose; a counter keeps long spans cheap
    int since_set;
    logic latch_q;
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            since_set <= 0;
            latch_q <= 1'h0;
        end else begin
            since_set <= (start_latch && !latch_q) ? 1 : since_set + 1;
            latch_q <= start_latch;
        end
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    set_on_edge_a: assert property ($fell(serial_in) && !start_latch && shifter_enable_n |-> ##[1:5] start_latch)
        else $error("latch not set after start edge");
    latch_hold_a: assert property ($rose(start_latch) |=> start_latch [*8])
        else $error("latch dropped early");
    clear_time_a: assert property ($fell(start_latch) |-> since_set inside {[CLR - 3:CLR + 3]})
        else $error("latch cleared at wrong time");
    half_delay_a: assert property ($fell(shifter_enable_n) |-> since_set inside {[HALF - 4:HALF + 4]})
        else $error("shift start not half a bit after latch");
    shift_gate_a: assert property ($fell(shifter_enable_n) |-> start_latch)
        else $error("shifter enabled without latch");
    frame_end_a: assert property ($rose(shifter_enable_n) |-> since_set inside {[ENDC - 8:ENDC + 8]})
        else $error("frame end at wrong time");
    byte_ready_a: assert property ($rose(shifter_enable_n) && !data_valid |-> ##[0:2] data_valid)
        else $error("byte not presented at frame end");
    hold_data_a: assert property (data_valid && !data_ready |=> data_valid && $stable(data_out))
        else $error("byte lost while stalled");
    freeze_hold_a: assert property (!clk_en |=> $stable(data_valid) && $stable(data_out))
        else $error("byte changed while clock enable low");
endmodule

bind ubrt_receiver ubrt_checker #(.CLK_KHZ(CLK_KHZ), .BAUD(BAUD), .HALF_BIT_US(HALF_BIT_US),
    .CLEAR_US(CLEAR_US)) i_ubrt_checker (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
    .serial_in(serial_in), .data_out(data_out), .data_valid(data_valid), .data_ready(data_ready),
    .start_latch(start_latch), .shifter_enable_n(shifter_enable_n));

// *** verif/ubrt_host_tx.sv ***
module ubrt_host_tx #(
    parameter int BIT = 104
) (
    input wire logic core_clk,
    output logic serial_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // Line idles high between frames
    initial serial_in = 1'h1;
    // Start low, data LSB first, stop high; each bit lasts BIT cycles
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] frame;
        frame = {1'h1, b, 1'h0};
        for (int i = 0; i < 10; i++) begin
            @(posedge core_clk);
            serial_in <= frame[i];
            repeat (BIT - 1) @(posedge core_clk);
        end
    endtask
endmodule

// *** verif/tb_top.sv ***
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin n_errors++; \
    $display("ERROR %s expected %h seen %h", n, e, s); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 1'h0;
    logic reset_n = 1'h0;
    logic data_ready = 1'h0;
    logic clk_en = 1'h1;
    logic serial_in;
    logic [7:0] data_out;
    logic data_valid, start_latch, shifter_enable_n;
    int n_errors = 0;
    int samples_checked = 0;
    // Scaled clock figure keeps a frame near a thousand cycles
    ubrt_receiver #(.CLK_KHZ(1000)) i_ubrt_receiver (.core_clk(core_clk), .reset_n(reset_n), .clk_en(clk_en),
        .serial_in(serial_in), .data_out(data_out), .data_valid(data_valid), .data_ready(data_ready),
        .start_latch(start_latch), .shifter_enable_n(shifter_enable_n));
    ubrt_host_tx #(.BIT(104)) i_ubrt_host_tx (.core_clk(core_clk), .serial_in(serial_in));
    always #5 core_clk = ~core_clk;
    // Wait for a byte, compare it, then take it with one ready cycle
    task automatic pop(input logic [7:0] e);
        for (int n = 0; n < 3000 && data_valid !== 1'h1; n++) @(negedge core_clk);
        `CHK("data_valid", 1'h1, data_valid)
        `CHK("data_out", e, data_out)
        @(posedge core_clk);
        data_ready <= 1'h1;
        @(posedge core_clk);
        data_ready <= 1'h0;
        @(negedge core_clk);
    endtask
    task automatic t_single();
        i_ubrt_host_tx.send_byte(8'hA5);
        pop(8'hA5);
    endtask
    // Stalled consumer: two bytes kept in order, the third dropped
    task automatic t_stall();
        i_ubrt_host_tx.send_byte(8'h3C);
        i_ubrt_host_tx.send_byte(8'h81);
        i_ubrt_host_tx.send_byte(8'hFF);
        repeat (200) @(negedge core_clk);
        pop(8'h3C);
        pop(8'h81);
        `CHK("data_valid", 1'h0, data_valid)
    endtask
    // Clock enable low freezes the buffer: a ready pulse then takes nothing
    task automatic t_freeze();
        i_ubrt_host_tx.send_byte(8'h96);
        @(posedge core_clk);
        clk_en <= 1'h0;
        data_ready <= 1'h1;
        repeat (4) @(posedge core_clk);
        data_ready <= 1'h0;
        @(negedge core_clk);
        `CHK("data_valid", 1'h1, data_valid)
        `CHK("data_out", 8'h96, data_out)
        @(posedge core_clk);
        clk_en <= 1'h1;
        pop(8'h96);
    endtask
    // Reset with a byte waiting clears the outputs; a frame after release still lands
    task automatic t_reset();
        i_ubrt_host_tx.send_byte(8'h5A);
        @(negedge core_clk);
        `CHK("data_out", 8'h5A, data_out)
        @(posedge core_clk);
        reset_n <= 1'h0;
        @(negedge core_clk);
        `CHK("data_valid", 1'h0, data_valid)
        `CHK("data_out", 8'h00, data_out)
        `CHK("start_latch", 1'h0, start_latch)
        `CHK("shifter_enable_n", 1'h1, shifter_enable_n)
        @(posedge core_clk);
        reset_n <= 1'h1;
        i_ubrt_host_tx.send_byte(8'hC3);
        pop(8'hC3);
    endtask
    task automatic test_done();
        $display("checked %0d errors %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Seven frames need about 7500 cycles; the limit leaves more than twice that
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        test_done();
    end
    initial begin
        repeat (3) @(posedge core_clk);
        reset_n <= 1'h1;
        t_single();
        t_stall();
        t_freeze();
        t_reset();
        test_done();
    end
endmodule
